/* File: design/tsc_touch_irq.sv */
// Top of the touch digitizer command decoder and pen interrupt logic.
`timescale 1ns/100ps
module tsc_touch_irq #(
  parameter logic [2:0] BATTERY_CHAN = 3'h2
) (
  // System clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Serial command link.
  input wire logic serial_clock_i,
  input wire logic serial_data_i,
  // Converter and panel status.
  input wire logic touch_sense_i,
  input wire logic conv_done_i,
  input wire logic sampling_i,
  // Decoded command.
  output logic [2:0] channel_sel_o,
  output logic resolution_8bit_o,
  output logic reference_mode_select_o,
  output logic ref_from_drivers_o,
  output logic ref_from_pin_o,
  output logic [1:0] power_ctl_o,
  output logic battery_divider_on_o,
  output logic cmd_valid_o,
  // Open-drain touch interrupt.
  output logic touch_irq_n_o,
  output logic touch_irq_oe_o
);
  import tsc_pkg::*;

  // ----------------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------------
  if (BATTERY_CHAN > 3'h7) begin : g_bad_chan
    $error("Battery channel code out of range.");
  end

  // ----------------------------------------------------------------------------
  // Link side and crossings
  // ----------------------------------------------------------------------------
  logic [CMD_W-1:0] link_word;
  logic word_toggle;
  logic start_toggle;
  logic release_toggle;
  logic [3:0] sync_in;
  logic [3:0] sync_out;

  // Serial front end on the link clock.
  tsc_cmd_shift u_shift (
    .serial_clock_i(serial_clock_i),
    .rst_i(rst_i),
    .serial_data_i(serial_data_i),
    .cmd_word_o(link_word),
    .word_toggle_o(word_toggle),
    .start_toggle_o(start_toggle),
    .release_toggle_o(release_toggle)
  );

  // Toggles and the touch comparator pass two flip-flops.
  assign sync_in = {touch_sense_i, release_toggle, word_toggle, start_toggle};

  tsc_sync #(.W(4)) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i(sync_in),
    .sync_o(sync_out)
  );

  logic touch_s;
  logic release_s;
  logic word_s;
  logic start_s;

  // Named views of the synchronised vector.
  assign touch_s = sync_out[3];
  assign release_s = sync_out[2];
  assign word_s = sync_out[1];
  assign start_s = sync_out[0];

  // ----------------------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------------------
  logic release_prev;
  logic word_prev;
  logic start_prev;
  logic release_evt;
  logic word_evt;
  logic start_evt;

  // A change of a synchronised toggle is one event.
  assign release_evt = release_s ^ release_prev;
  assign word_evt = word_s ^ word_prev;
  assign start_evt = start_s ^ start_prev;

  // Previous toggle levels.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      release_prev <= 1'b0;
      word_prev <= 1'b0;
      start_prev <= 1'b0;
    end else begin
      release_prev <= release_s;
      word_prev <= word_s;
      start_prev <= start_s;
    end
  end

  // ----------------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------------
  logic [2:0] next_channel;
  logic next_res8;
  logic next_ref_mode;
  logic [1:0] next_power;
  logic next_battery;

  // The held link word is stable for many cycles after its toggle.
  always_comb begin
    next_channel = channel_sel_o;
    next_res8 = resolution_8bit_o;
    next_ref_mode = reference_mode_select_o;
    next_power = power_ctl_o;
    if (word_evt) begin
      next_channel = link_word[CHAN_HI:CHAN_LO];
      next_res8 = link_word[MODE_BIT];
      next_ref_mode = link_word[REF_BIT];
      next_power = link_word[PD_HI:PD_LO];
    end
    next_battery = sampling_i && channel_sel_o == BATTERY_CHAN;
  end

  // Command registers; the divider itself scales by BATTERY_DIVIDE.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      channel_sel_o <= CHAN_RESET;
      resolution_8bit_o <= MODE_RESET;
      reference_mode_select_o <= REF_RESET;
      ref_from_pin_o <= REF_RESET;
      ref_from_drivers_o <= ~REF_RESET;
      power_ctl_o <= PD_RESET;
      battery_divider_on_o <= 1'b0;
      cmd_valid_o <= 1'b0;
    end else begin
      channel_sel_o <= next_channel;
      resolution_8bit_o <= next_res8;
      reference_mode_select_o <= next_ref_mode;
      ref_from_pin_o <= next_ref_mode;
      ref_from_drivers_o <= ~next_ref_mode;
      power_ctl_o <= next_power;
      battery_divider_on_o <= next_battery;
      cmd_valid_o <= word_evt;
    end
  end

  // ----------------------------------------------------------------------------
  // Pen interrupt
  // ----------------------------------------------------------------------------
  logic detect_en;
  logic next_detect_en;
  logic armed;
  logic next_armed;
  logic next_hold;

  // Detection, arming by a new word and the open-drain hold.
  always_comb begin
    next_detect_en = detect_en;
    next_armed = armed;
    next_hold = touch_irq_oe_o;
    if (start_evt) begin
      next_armed = 1'b0;
    end else if (word_evt) begin
      next_armed = 1'b1;
    end else if (conv_done_i) begin
      next_armed = 1'b0;
    end
    if (start_evt) begin
      next_detect_en = 1'b0;
    end else if (conv_done_i && armed) begin
      next_detect_en = power_ctl_o != PD_ALWAYS_ON;
    end
    if (release_evt) begin
      next_hold = 1'b0;
    end else if (detect_en) begin
      next_hold = touch_s;
    end
  end

  // Interrupt registers.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      detect_en <= 1'b1;
      armed <= 1'b0;
      touch_irq_oe_o <= 1'b0;
      touch_irq_n_o <= 1'b1;
    end else begin
      detect_en <= next_detect_en;
      armed <= next_armed;
      touch_irq_oe_o <= next_hold;
      touch_irq_n_o <= ~next_hold;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  start_off_a: assert property (start_evt |=> !detect_en)
    else $error("Start did not disable detection.");
  release_high_a: assert property (release_evt |=> !touch_irq_oe_o && touch_irq_n_o)
    else $error("Interrupt not released after fourth falling edge.");
  reenable_cause_a: assert property ($rose(detect_en) |-> $past(conv_done_i) && $past(armed))
    else $error("Detection enabled without a completed conversion.");
  always_on_a: assert property (
    conv_done_i && !start_evt && power_ctl_o == PD_ALWAYS_ON && !detect_en |=> !detect_en)
    else $error("Power code 11 enabled detection.");
  pin_level_a: assert property (touch_irq_oe_o |-> !touch_irq_n_o)
    else $error("Open-drain enable without a low level.");
  touch_low_a: assert property (detect_en && touch_s && !release_evt |=> touch_irq_oe_o)
    else $error("Enabled touch did not pull the interrupt low.");
  no_touch_a: assert property (detect_en && !touch_s |=> !touch_irq_oe_o)
    else $error("Interrupt low without a touch.");
  battery_sw_a: assert property (
    battery_divider_on_o |-> $past(sampling_i) && $past(channel_sel_o) == BATTERY_CHAN)
    else $error("Battery divider closed outside battery sampling.");
  word_load_a: assert property (
    word_evt |=> channel_sel_o == $past(link_word[CHAN_HI:CHAN_LO]) && cmd_valid_o)
    else $error("Channel select not loaded from the word.");
  mode_load_a: assert property (word_evt |=> resolution_8bit_o == $past(link_word[MODE_BIT]))
    else $error("Resolution not loaded from the word.");
  ref_path_a: assert property (ref_from_pin_o == reference_mode_select_o ##0 ref_from_drivers_o != ref_from_pin_o)
    else $error("Reference source does not follow the reference mode.");

  // ----------------------------------------------------------------------------
  // Field and interrupt checks
  // ----------------------------------------------------------------------------
  // Every field of a word lands together with its valid pulse.
  ref_load_a: assert property (
    word_evt |=> reference_mode_select_o == $past(link_word[REF_BIT]))
    else $error("Reference mode not loaded from the word.");
  power_load_a: assert property (
    word_evt |=> power_ctl_o == $past(link_word[PD_HI:PD_LO]))
    else $error("Power bits not loaded from the word.");
  // Between words the decoded fields hold their values.
  fields_hold_a: assert property (
    !word_evt |=> $stable(channel_sel_o) && $stable(resolution_8bit_o) && $stable(power_ctl_o))
    else $error("Decoded fields changed without a word.");
  // Words arrive many cycles apart, so the valid strobe is a single cycle.
  valid_pulse_a: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("Command valid held for more than one cycle.");

  // A start always drops the arming left by an earlier word.
  start_disarm_a: assert property (start_evt |=> !armed)
    else $error("Start left the detection armed.");
  // A word with no start beside it arms the next completion.
  word_arm_a: assert property (word_evt && !start_evt |=> armed)
    else $error("Loaded word did not arm detection.");
  // Without a word since the last start, completion cannot re-enable detection.
  overlap_off_a: assert property (!armed && !detect_en |=> !detect_en)
    else $error("Detection enabled without a new word.");
  // A completed armed conversion with a detecting power code turns detection on.
  reenable_code_a: assert property (
    conv_done_i && armed && !start_evt && power_ctl_o != PD_ALWAYS_ON |=> detect_en)
    else $error("Detecting power code did not re-enable detection.");
  // While detection is off the pin only moves on a release.
  held_off_a: assert property (!detect_en && !release_evt |=> $stable(touch_irq_oe_o))
    else $error("Interrupt moved while detection was off.");
  // An idle pin stays idle while detection is off.
  idle_off_a: assert property (!detect_en && !touch_irq_oe_o |=> !touch_irq_oe_o)
    else $error("Interrupt fell while detection was off.");
  // The pin only falls on an enabled, synchronised touch.
  fall_cause_a: assert property ($fell(touch_irq_n_o) |-> $past(detect_en) && $past(touch_s))
    else $error("Interrupt fell without an enabled touch.");
  // The divider opens as soon as sampling stops.
  battery_off_a: assert property (!sampling_i |=> !battery_divider_on_o)
    else $error("Battery divider closed while not sampling.");

  start_release_c: cover property (start_evt ##[1:200] release_evt);
  reenable_c: cover property (!detect_en ##1 detect_en ##[1:100] touch_irq_oe_o);
  battery_c: cover property (battery_divider_on_o);
  overlap_c: cover property (conv_done_i && !armed && !detect_en);
  word_8bit_c: cover property (cmd_valid_o && resolution_8bit_o);
endmodule : tsc_touch_irq

/* File: design/tsc_pkg.sv */
// Shared constants and types of the touch digitizer command decoder and pen interrupt.
// ------------------------------------------------------------------------------
// ------------------------------------------------------------------------------
package tsc_pkg;
  // Command word layout.
  localparam int CMD_W = 8;
  localparam int START_BIT = 7;
  localparam int CHAN_HI = 6;
  localparam int CHAN_LO = 4;
  localparam int MODE_BIT = 3;
  localparam int REF_BIT = 2;
  localparam int PD_HI = 1;
  localparam int PD_LO = 0;
  // Reset values.
  localparam logic [1:0] PD_RESET = 2'h2;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam logic MODE_RESET = 1'h0;
  localparam logic REF_RESET = 1'h1;
  localparam logic [CMD_W-1:0] WORD_RESET = 8'h00;
  // Power code that keeps everything on and detection off.
  localparam logic [1:0] PD_ALWAYS_ON = 2'h3;
  // Battery divider ratio, realised in the analog divider.
  localparam int BATTERY_DIVIDE = 4;
  // Serial edge counts, counted from the start bit edge as one.
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_START = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_TWO = 4'h2;
  localparam logic [CNT_W-1:0] CNT_LAST_BIT = 4'h7;
  localparam logic [CNT_W-1:0] RELEASE_FALL = 4'h4;
  localparam logic [CNT_W-1:0] FRAME_12 = 4'hf;
  localparam logic [CNT_W-1:0] FRAME_8 = 4'hb;
  // Serial front end states.
  typedef enum logic [1:0] {
    TSC_IDLE = 2'b00,
    TSC_CAPTURE = 2'b01,
    TSC_GAP = 2'b10
  } tsc_shift_state_type;
endpackage : tsc_pkg

/* File: design/tsc_sync.sv */
// Two-stage synchroniser for levels and toggles entering the system clock.
`timescale 1ns/100ps
module tsc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Asynchronous in, synchronised out.
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] stage1;

  // First stage feeds only the second stage.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule : tsc_sync

/* File: design/tsc_cmd_shift.sv */
// Serial-clock front end: start detection, command capture and release timing.
`timescale 1ns/100ps
module tsc_cmd_shift (
  // Link clock and reset.
  input wire logic serial_clock_i,
  input wire logic rst_i,
  // Serial command input.
  input wire logic serial_data_i,
  // Held word and event toggles toward the system clock.
  output logic [tsc_pkg::CMD_W-1:0] cmd_word_o,
  output logic word_toggle_o,
  output logic start_toggle_o,
  output logic release_toggle_o
);
  import tsc_pkg::*;

  tsc_shift_state_type state;
  tsc_shift_state_type next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CMD_W-2:0] shift;
  logic [CMD_W-2:0] next_shift;
  logic [CMD_W-1:0] next_word;
  logic next_word_toggle;
  logic next_start_toggle;
  logic [CNT_W-1:0] frame;

  // Next state of the rising-edge front end.
  always_comb begin
    next_state = state;
    next_count = 4'(count + CNT_ONE);
    next_shift = shift;
    next_word = cmd_word_o;
    next_word_toggle = word_toggle_o;
    next_start_toggle = start_toggle_o;
    frame = cmd_word_o[MODE_BIT] ? FRAME_8 : FRAME_12;
    unique case (state)
      TSC_IDLE: begin
        next_count = CNT_START;
        if (serial_data_i) begin
          next_state = TSC_CAPTURE;
          next_start_toggle = ~start_toggle_o;
        end
      end
      TSC_CAPTURE: begin
        next_shift = {shift[CMD_W-3:0], serial_data_i};
        if (count == CNT_LAST_BIT) begin
          next_state = TSC_GAP;
          next_word = {1'b1, shift[CMD_W-3:0], serial_data_i};
          next_word_toggle = ~word_toggle_o;
        end
      end
      TSC_GAP: begin
        if (count == 4'(frame - CNT_TWO)) begin
          next_state = TSC_IDLE;
        end
      end
      default: begin
        next_state = TSC_IDLE;
      end
    endcase
  end

  // Rising-edge registers.
  always_ff @(posedge serial_clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= TSC_IDLE;
      count <= CNT_START;
      shift <= '0;
      cmd_word_o <= WORD_RESET;
      word_toggle_o <= 1'b0;
      start_toggle_o <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      shift <= next_shift;
      cmd_word_o <= next_word;
      word_toggle_o <= next_word_toggle;
      start_toggle_o <= next_start_toggle;
    end
  end

  always_ff @(negedge serial_clock_i or posedge rst_i) begin
    if (rst_i) begin
      release_toggle_o <= 1'b0;
    end else if (state == TSC_CAPTURE && count == RELEASE_FALL) begin
      release_toggle_o <= ~release_toggle_o;
    end
  end

  // Idle ignores a low input.
  start_ignore_a: assert property (@(posedge serial_clock_i) disable iff (rst_i)
    state == TSC_IDLE && !serial_data_i |=> state == TSC_IDLE && $stable(start_toggle_o))
    else $error("Low serial level left idle.");
  // A word lands seven edges after its start.
  word_timing_a: assert property (@(posedge serial_clock_i) disable iff (rst_i)
    state == TSC_IDLE && serial_data_i |=> ##7 $changed(word_toggle_o) && cmd_word_o[START_BIT])
    else $error("Command word not captured on the eighth edge.");
endmodule : tsc_cmd_shift

/* File: testbench/tsc_host_model.sv */
// Host model that clocks command words into the digitizer over the serial link.
`timescale 1ns/100ps
module tsc_host_model (
  // Serial link driven by the host.
  output logic serial_clock_o,
  output logic serial_data_o
);
  // The link clock stands low between frames.
  initial begin
    serial_clock_o = 1'b0;
    serial_data_o = 1'b0;
  end

  // Emits edges lo to hi-1 of a bit string, MSB first, data set just after the clock falls.
  task automatic emit(input logic [14:0] bits, input int lo, input int hi);
    for (int i = lo; i < hi; i++) begin
      #1 serial_data_o = bits[14-i];
      #2 serial_clock_o = 1'b1;
      #3 serial_clock_o = 1'b0;
    end
    // The line no longer carries the last bit once the host lets go.
    serial_data_o = ~serial_data_o;
  endtask : emit

  // frame spacing
  // One frame: word, then filler with highs the device must ignore; last edge low.
  task automatic send_frame(input logic [7:0] word);
    emit({word, 7'h6a}, 0, word[3] ? 11 : 15);
  endtask : send_frame
endmodule : tsc_host_model

/* File: testbench/tsc_touch_irq_tb.sv */
// Self-checking bench of the touch command decoder and pen interrupt.
`timescale 1ns/100ps
module tsc_touch_irq_tb;
  import tsc_pkg::*;
  // Battery channel handed to the design and a position channel for ratiometric use.
  localparam logic [2:0] batt_chan = 3'h2;
  localparam logic [2:0] pos_chan = 3'h1;
  // Cross-plate channel codes for the resistance sequence; the values are arbitrary.
  localparam logic [2:0] cross_1_chan = 3'h3;
  localparam logic [2:0] cross_2_chan = 3'h4;
  logic clock_i, rst_i, touch_sense_i, conv_done_i, sampling_i;
  wire logic serial_clock;
  wire logic serial_data;
  logic [2:0] chan;
  logic res8, refsel, drv, pin_ref, batt_on, cmd_valid, irq_n, irq_oe;
  logic [1:0] pwr;
  wire logic irq_pin;
  logic [10:0] seen_q[$];
  logic [7:0] w;
  int bad_count, n_checks;

  tsc_touch_irq #(.BATTERY_CHAN(batt_chan)) u_tsc_touch_irq (
    .clock_i(clock_i), .rst_i(rst_i), .serial_clock_i(serial_clock), .serial_data_i(serial_data),
    .touch_sense_i(touch_sense_i), .conv_done_i(conv_done_i), .sampling_i(sampling_i),
    .channel_sel_o(chan), .resolution_8bit_o(res8), .reference_mode_select_o(refsel),
    .ref_from_drivers_o(drv), .ref_from_pin_o(pin_ref), .power_ctl_o(pwr),
    .battery_divider_on_o(batt_on), .cmd_valid_o(cmd_valid), .touch_irq_n_o(irq_n),
    .touch_irq_oe_o(irq_oe)
  );
  tsc_host_model u_tsc_host_model (.serial_clock_o(serial_clock), .serial_data_o(serial_data));

  // Open-drain pin with its pull-up.
  assign irq_pin = irq_oe ? 1'b0 : 1'b1;

  // System clock at 125 MHz.
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // Records the decoded outputs and the pin state at every word load.
  always @(posedge clock_i) begin
    if (cmd_valid === 1'b1) begin
      seen_q.push_back({chan, res8, refsel, drv, pin_ref, pwr, irq_oe, irq_n});
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Builds a command word with its start marker set.
  function automatic logic [7:0] mk(input logic [2:0] ch, input logic r8, input logic se, input logic [1:0] pd);
    return {1'b1, ch, r8, se, pd};
  endfunction : mk

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // Compares one value and reports a mismatch.
  task automatic check(input logic [10:0] got, input logic [10:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // Waits whole cycles, landing just after a rising edge.
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : wait_cyc

  // Waits a bounded time for the pin level; running out ends the run.
  task automatic wait_pin(input logic exp, input int max);
    int i;
    i = 0;
    while (irq_pin !== exp && i < max) begin
      wait_cyc(1);
      i++;
    end
    check({10'h0, irq_pin}, {10'h0, exp}, "irq pin");
    if (irq_pin !== exp) close_out();
  endtask : wait_pin

  // Waits a bounded time for the next word load and compares every field.
  task automatic expect_word(input logic [7:0] wd);
    int i;
    i = 0;
    while (seen_q.size() == 0 && i < 60) begin
      wait_cyc(1);
      i++;
    end
    if (seen_q.size() == 0) begin
      bad_count++;
      $display("BAD %0t no word loaded", $time);
      close_out();
    end
    check(seen_q.pop_front(), {wd[6:4], wd[3], wd[2], ~wd[2], wd[2], wd[1:0], 2'b01}, "word");
  endtask : expect_word

  // One-cycle conversion-complete pulse.
  task automatic pulse_done();
    wait_cyc(1);
    conv_done_i = 1'b1;
    wait_cyc(1);
    conv_done_i = 1'b0;
  endtask : pulse_done

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    touch_sense_i = 1'b0;
    conv_done_i = 1'b0;
    sampling_i = 1'b0;
    bad_count = 0;
    n_checks = 0;
    wait_cyc(6);
    check({chan, res8, refsel, drv, pin_ref, pwr, irq_oe, irq_n}, 11'h059, "reset");
    rst_i = 1'b0;
    wait_cyc(2);
    // A touch right after power-up pulls the pin low.
    touch_sense_i = 1'b1;
    wait_pin(1'b0, 10);
    // Word while touched: released before the load, and not re-armed by the release.
    w = mk(3'h5, 1'b1, 1'b1, 2'h0);
    u_tsc_host_model.emit(15'h0, 0, 3);
    u_tsc_host_model.send_frame(w);
    expect_word(w);
    wait_cyc(20);
    check({10'h0, irq_pin}, 11'h1, "held off");
    pulse_done();
    wait_pin(1'b0, 6);
    // Each power code, ratiometric on a position channel, then conversion end.
    for (int p = 0; p < 4; p++) begin
      w = mk(pos_chan, 1'b0, 1'b0, p[1:0]);
      u_tsc_host_model.send_frame(w);
      expect_word(w);
      pulse_done();
      wait_cyc(6);
      check({10'h0, irq_pin}, {10'h0, p == 3}, "power code");
    end
    // Touch resistance: position, then both cross-plate readings, all ratiometric.
    for (int k = 0; k < 3; k++) begin
      w = mk(k == 0 ? pos_chan : k == 1 ? cross_1_chan : cross_2_chan, 1'b0, 1'b0, 2'h0);
      u_tsc_host_model.send_frame(w);
      expect_word(w);
      pulse_done();
      wait_pin(1'b0, 6);
    end
    touch_sense_i = 1'b0;
    // Every channel, alternating resolution, with the battery divider per channel.
    for (int c = 0; c < 8; c++) begin
      w = mk(c[2:0], c[0], 1'b1, 2'h3);
      u_tsc_host_model.send_frame(w);
      expect_word(w);
      sampling_i = 1'b1;
      wait_cyc(3);
      check({10'h0, batt_on}, {10'h0, c[2:0] == batt_chan}, "divider sampling");
      sampling_i = 1'b0;
      wait_cyc(3);
      check({10'h0, batt_on}, 11'h0, "divider idle");
    end
    // Back-to-back frames at the minimum spacing of each resolution.
    u_tsc_host_model.send_frame(mk(3'h3, 1'b1, 1'b1, 2'h3));
    u_tsc_host_model.send_frame(mk(3'h4, 1'b0, 1'b1, 2'h3));
    u_tsc_host_model.send_frame(mk(3'h6, 1'b1, 1'b1, 2'h0));
    expect_word(mk(3'h3, 1'b1, 1'b1, 2'h3));
    expect_word(mk(3'h4, 1'b0, 1'b1, 2'h3));
    expect_word(mk(3'h6, 1'b1, 1'b1, 2'h0));
    wait_cyc(10);
    check({10'h0, seen_q.size() == 0}, 11'h1, "no spurious word");
    pulse_done();
    // Overlapped write: a start before conversion end keeps detection off.
    w = mk(3'h2, 1'b0, 1'b1, 2'h0);
    u_tsc_host_model.emit({w, 7'h6a}, 0, 4);
    pulse_done();
    touch_sense_i = 1'b1;
    wait_cyc(10);
    check({10'h0, irq_pin}, 11'h1, "overlap off");
    u_tsc_host_model.emit({w, 7'h6a}, 4, 15);
    expect_word(w);
    pulse_done();
    wait_pin(1'b0, 6);
    touch_sense_i = 1'b0;
    wait_pin(1'b1, 6);
    close_out();
  end
endmodule : tsc_touch_irq_tb
